/* File: hdl/ibj_exec.sv */
/*
 * Execution of the indirect RAM increment, the data pointer increment
 * and the jump-if-bit-set instruction.
 * Assumes the core presents a one-cycle i_start with the opcode, the
 * tested bit value and the displacement byte already fetched, and holds
 * the indirect pointer register values steady while the block is busy.
 */
//
// Overview of operation
// [RQ1] Opcode A3 adds one to data pointer pair
// [RQ2] Low byte wrap carries into high byte
// [RQ3] Pointer increment keeps flags, takes two cycles
// [RQ4] Opcode 20 branches when addressed bit one
// [RQ5] Target is PC plus three plus displacement
// [RQ6] Tested bit is never written back
// [RQ7] Opcode 0000011i increments RAM byte via pointer
`timescale 1ns/1ns
module ibj_exec
    import ibj_pkg::*;
(
    input  wire logic        i_core_clk,   // Core clock, 10 MHz
    input  wire logic        i_rst,        // Async reset, active high
    input  wire logic        i_start,      // Opcode valid, one-cycle pulse
    input  wire logic [7:0]  i_opcode,     // Fetched opcode byte
    input  wire logic [15:0] i_pc,         // Address of the opcode
    input  wire logic        i_bit_value,  // Value of addressed bit
    input  wire logic [7:0]  i_rel,        // Third byte, signed offset
    input  wire logic [7:0]  i_ind_ptr0,   // Indirect pointer register 0
    input  wire logic [7:0]  i_ind_ptr1,   // Indirect pointer register 1
    input  wire logic [7:0]  i_flags_in,   // Status flags from core
    output logic             o_busy,       // Instruction in progress
    output logic             o_done,       // Completion pulse
    output logic             o_pc_load,    // Load o_pc_next into PC
    output logic [15:0]      o_pc_next,    // Next program counter
    output logic             o_branch,     // Last jump was taken
    output logic [7:0]       o_pointer_low_byte,  // Data pointer low
    output logic [7:0]       o_pointer_high_byte, // Data pointer high
    output logic [7:0]       o_flags_out   // Status flags to core
);
    import ibj_pkg::*;

    // Cycle plan, counted from the edge that takes i_start:
    //   indirect RAM increment: the read is issued at the taking edge,
    //   the sum is written one edge later, done stands after that edge.
    //   Pointer increment: the pair steps at the taking edge and done
    //   follows one edge later, so the new pair is seen a cycle early.
    //   Jump: target and branch marker register at the taking edge;
    //   done and the PC load pulse follow together one edge later.
    // A start while busy is dropped, not queued: a queue would need a
    // second copy of every operand, and the core waits for done anyway.

    // Shared opcode decode
    function automatic logic is_inc_ind(input logic [7:0] op);
        is_inc_ind = (op & OP_INC_IND_MASK) == OP_INC_IND;
    endfunction

    ibj_state_e    state_q, state_d;
    logic [15:0]   ptr_q, ptr_d;
    logic [15:0]   pc_q, pc_d;
    logic          pc_load_q, pc_load_d;
    logic          done_q, done_d;
    logic          branch_q, branch_d;
    logic [7:0]    flags_q, flags_d;
    logic [7:0]    ram_addr_q, ram_addr_d;
    logic [7:0]    ram_rdata;
    logic          ram_we;
    logic [7:0]    ram_raddr;
    logic [15:0]   ptr_sum;
    logic [15:0]   rel_ext;
    logic [15:0]   jb_seq_pc;
    logic [15:0]   jb_taken_pc;
    logic          busy_q, busy_d;
    logic          is_jump_q, is_jump_d;

    // Sixteen-bit add carries low-byte wrap into the high byte
    assign ptr_sum   = ptr_q + PTR_STEP;                           // [RQ1] [RQ2]
    assign rel_ext   = {{8{i_rel[7]}}, i_rel};                     // [RQ5]
    // Sequential address first, then the displacement on top of it
    assign jb_seq_pc   = i_pc + JB_LENGTH;                         // [RQ5]
    assign jb_taken_pc = jb_seq_pc + rel_ext;                      // [RQ5]
    assign ram_raddr = i_opcode[0] ? i_ind_ptr1 : i_ind_ptr0;      // [RQ7]
    // Write back happens the cycle after the registered read returns.
    // The read issued in that cycle is discarded; no start is taken
    // while the write is pending, so no stale byte is ever summed.
    assign ram_we    = (state_q == IBJ_RAM_WAIT);

    ibj_ram #(
        .AW (RAM_AW),
        .DW (RAM_DW)
    ) u_ram (
        .i_core_clk (i_core_clk),
        .i_raddr    (ram_raddr),
        .o_rdata    (ram_rdata),
        .i_we       (ram_we),
        .i_waddr    (ram_addr_q),
        .i_wdata    (ram_rdata + BYTE_STEP)                        // [RQ7]
    );

    // Next-state and datapath decisions
    always_comb
    begin
        state_d    = state_q;
        ptr_d      = ptr_q;
        pc_d       = pc_q;
        pc_load_d  = 1'b0;
        done_d     = 1'b0;
        branch_d   = branch_q;
        flags_d    = i_flags_in;   // Pass-through: no flag is altered  [RQ3]
        ram_addr_d = ram_addr_q;
        case (state_q)
            IBJ_IDLE:
            begin
                if (i_start)
                begin
                    if (is_inc_ind(i_opcode))
                    begin
                        ram_addr_d = ram_raddr;                    // [RQ7]
                        state_d    = IBJ_RAM_WAIT;
                    end
                    else if (i_opcode == OP_INC_PTR)
                    begin
                        ptr_d   = ptr_sum;                         // [RQ1]
                        state_d = IBJ_SECOND;                      // [RQ3]
                    end
                    else if (i_opcode == OP_JMP_BIT_SET)
                    begin
                        // Bit is only read, never written          [RQ6]
                        pc_d     = jb_seq_pc;                      // [RQ5]
                        branch_d = i_bit_value;                    // [RQ4]
                        if (i_bit_value)
                            pc_d = jb_taken_pc;                    // [RQ4]
                        state_d  = IBJ_SECOND;                     // [RQ5]
                    end
                    // Any other opcode belongs elsewhere: no answer
                end
            end
            IBJ_RAM_WAIT:
            begin
                // Increment lands now; done marks the end of the two-cycle op
                done_d  = 1'b1;                                    // [RQ7]
                state_d = IBJ_IDLE;
            end
            IBJ_SECOND:
            begin
                // Only a jump asks the core to reload its PC; the
                // pointer increment leaves the PC alone
                pc_load_d = is_jump_q;                             // [RQ4]
                done_d    = 1'b1;                                  // [RQ3]
                state_d   = IBJ_IDLE;
            end
            default:
            begin
                // Unused encoding: recover to idle
                state_d = IBJ_IDLE;
            end
        endcase
    end

    // Registers; outputs other than o_busy come straight from these flops
    // so the core never sees decode glitches on them
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q    <= IBJ_IDLE;
            ptr_q      <= PTR_RESET;
            pc_q       <= PC_RESET;
            pc_load_q  <= 1'b0;
            done_q     <= 1'b0;
            branch_q   <= 1'b0;
            flags_q    <= 8'h00;
            ram_addr_q <= 8'h00;
        end
        else
        begin
            state_q    <= state_d;
            ptr_q      <= ptr_d;
            pc_q       <= pc_d;
            pc_load_q  <= pc_load_d;
            done_q     <= done_d;
            branch_q   <= branch_d;
            flags_q    <= flags_d;
            ram_addr_q <= ram_addr_d;
        end
    end

    // Busy follows the next state, so it is high from the cycle after
    // the taking edge; that is what keeps a second start out. The jump
    // marker remembers which instruction is in flight, so the second
    // cycle knows whether to ask for a PC load.
    always_comb
    begin
        busy_d    = (state_d != IBJ_IDLE);
        is_jump_d = is_jump_q;
        if (i_start && state_q == IBJ_IDLE)
            is_jump_d = (i_opcode == OP_JMP_BIT_SET);
    end

    // Busy and jump marker registers
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            busy_q    <= 1'b0;
            is_jump_q <= 1'b0;
        end
        else
        begin
            busy_q    <= busy_d;
            is_jump_q <= is_jump_d;
        end
    end

    assign o_busy              = busy_q;
    assign o_done              = done_q;
    assign o_pc_load           = pc_load_q;
    assign o_pc_next           = pc_q;
    assign o_branch            = branch_q;
    assign o_pointer_low_byte  = ptr_q[7:0];
    assign o_pointer_high_byte = ptr_q[15:8];
    assign o_flags_out         = flags_q;
endmodule // ibj_exec

/* File: hdl/ibj_ram.sv */
/*
 * Internal scratch RAM with registered read data and one write port.
 * Assumes a single clock; read and write may happen in the same cycle.
 * Contents start cleared; the array itself has no reset.
 */
`timescale 1ns/1ns
module ibj_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          i_core_clk, // Core clock
    input  wire logic [AW-1:0] i_raddr,    // Read address
    output logic      [DW-1:0] o_rdata,    // Registered read data
    input  wire logic          i_we,       // Write enable
    input  wire logic [AW-1:0] i_waddr,    // Write address
    input  wire logic [DW-1:0] i_wdata     // Write data
);
    // Cleared at start so an increment always begins from a known byte
    logic [DW-1:0] mem_q [0:(1<<AW)-1] = '{default: '0};

    // Registered read keeps the path from the array short
    always_ff @(posedge i_core_clk)
    begin
        if (i_we)
            mem_q[i_waddr] <= i_wdata;
        o_rdata <= mem_q[i_raddr];
    end
endmodule // ibj_ram

/* File: shared/ibj_pkg.sv */
/*
 * Package for the increment and bit-jump execution block: opcodes,
 * instruction lengths, step sizes, RAM sizes, states and reset values.
 * Assumes the core delivers opcodes and operand bytes already fetched.
 */
package ibj_pkg;
    localparam logic [7:0]  OP_INC_IND_MASK = 8'hFE; // Low bit selects pointer
    localparam logic [7:0]  OP_INC_IND      = 8'h06;
    localparam logic [7:0]  OP_INC_PTR      = 8'hA3;
    localparam logic [7:0]  OP_JMP_BIT_SET  = 8'h20;
    localparam logic [15:0] JB_LENGTH       = 16'h0003;
    localparam logic [15:0] PTR_STEP        = 16'h0001;
    localparam logic [7:0]  BYTE_STEP       = 8'h01;
    localparam logic [15:0] PTR_RESET       = 16'h0000;
    localparam logic [15:0] PC_RESET        = 16'h0000;
    localparam int          RAM_DEPTH       = 256;
    localparam int          RAM_AW          = 8;
    localparam int          RAM_DW          = 8;

    typedef enum logic [1:0] {
        IBJ_IDLE,
        IBJ_RAM_WAIT,
        IBJ_SECOND
    } ibj_state_e;
endpackage

/* File: tb/ibj_exec_bench.sv */
/* Bench for ibj_exec: issues each instruction and checks the answers.
   Assumes the package constants and the hand-over timing. */
`timescale 1ns/1ns
module ibj_exec_bench;
    import ibj_pkg::*;
    logic        i_core_clk = 0, i_rst = 1, i_start = 0, i_bit_value = 0;
    logic [7:0]  i_opcode = 8'h00, i_rel = 8'h00, i_flags_in = 8'h00;
    logic [7:0]  i_ind_ptr0 = 8'h10, i_ind_ptr1 = 8'h11;
    logic [15:0] i_pc = 16'h0000, ptr_e = 16'h0000;
    logic        o_busy, o_done, o_pc_load, o_branch;
    logic [15:0] o_pc_next;
    logic [7:0]  o_pointer_low_byte, o_pointer_high_byte, o_flags_out;
    int          err_total = 0, n_tests = 0, n;
    always #50 i_core_clk = ~i_core_clk;
    ibj_exec DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_start(i_start),
        .i_opcode(i_opcode), .i_pc(i_pc), .i_bit_value(i_bit_value),
        .i_rel(i_rel), .i_ind_ptr0(i_ind_ptr0), .i_ind_ptr1(i_ind_ptr1),
        .i_flags_in(i_flags_in), .o_busy(o_busy), .o_done(o_done),
        .o_pc_load(o_pc_load), .o_pc_next(o_pc_next), .o_branch(o_branch),
        .o_pointer_low_byte(o_pointer_low_byte),
        .o_pointer_high_byte(o_pointer_high_byte), .o_flags_out(o_flags_out));
    // Compare and count; case inequality so unknowns never match
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One instruction; returns just after the taking edge
    task automatic issue(input logic [7:0] op, input logic [15:0] pc,
                         input logic [7:0] rel, input logic b);
        @(posedge i_core_clk);
        i_start <= 1'b1;
        i_opcode <= op;
        i_pc <= pc;
        i_rel <= rel;
        i_bit_value <= b;
        i_flags_in <= rel; // Varying flags show any modification
        @(posedge i_core_clk);
        i_start <= 1'b0;
        #1;
        chk({8'h00, o_flags_out}, {8'h00, rel});
    endtask
    // Bounded wait for completion; n counts the edges taken
    task automatic wait_done;
        n = 1;
        while (o_done !== 1'b1)
        begin
            @(posedge i_core_clk);
            #1;
            n++;
            if (n > 8)
            begin
                err_total++;
                finish_test;
            end
        end
    endtask
    // 257 steps cross the low byte wrap into the high byte
    task automatic t_ptr;
        repeat (257)
        begin
            issue(OP_INC_PTR, 16'h0000, ptr_e[7:0] + 8'h01, 1'b0);
            ptr_e = ptr_e + 16'h0001;
            chk({o_pointer_high_byte, o_pointer_low_byte}, ptr_e);
            wait_done;
            chk(n[15:0], 16'h0002);
            chk({15'h0000, o_pc_load}, 16'h0000);
        end
        $display("pointer increment test done");
    endtask
    // Backward, wrapping and not-taken jumps
    task automatic t_jb;
        logic [15:0] pcs [3] = '{16'h0100, 16'hFFFE, 16'h1234};
        logic [7:0]  rels [3] = '{8'hFE, 8'h05, 8'h80};
        logic        bs [3] = '{1'b1, 1'b1, 1'b0};
        logic [15:0] e;
        for (int i = 0; i < 3; i++)
        begin
            e = pcs[i] + JB_LENGTH;
            if (bs[i])
                e = e + {{8{rels[i][7]}}, rels[i]};
            issue(OP_JMP_BIT_SET, pcs[i], rels[i], bs[i]);
            chk(o_pc_next, e);
            chk({15'h0000, o_branch}, {15'h0000, bs[i]});
            wait_done;
            chk(n[15:0], 16'h0002);
            chk({15'h0000, o_pc_load}, 16'h0001);
            chk({o_pointer_high_byte, o_pointer_low_byte}, ptr_e);
            @(posedge i_core_clk);
            #1;
            chk({15'h0000, o_pc_load}, 16'h0000);
        end
        $display("jump test done");
    endtask
    // 256 steps through pointer 0 wrap its byte; the last uses pointer 1
    task automatic t_ram;
        logic [7:0] e0;
        logic [7:0] e1;
        e0 = 8'h00;
        e1 = 8'h00;
        for (int i = 0; i < 257; i++)
        begin
            issue(OP_INC_IND | {7'h00, i[8]}, 16'h0000, 8'h3C, 1'b0);
            if (i[8])
                e1 = e1 + BYTE_STEP;
            else
                e0 = e0 + BYTE_STEP;
            chk({15'h0000, o_busy}, 16'h0001);
            wait_done;
            chk(n[15:0], 16'h0002);
            chk({DUT.u_ram.mem_q[i_ind_ptr1], DUT.u_ram.mem_q[i_ind_ptr0]},
                {e1, e0});
        end
        $display("ram increment test done");
    endtask
    // Reset in the cycle of the done pulse returns pointer, next PC, busy, done and PC load to idle
    task automatic t_rst;
        issue(OP_INC_PTR, 16'h0000, 8'h00, 1'b0);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        ptr_e = PTR_RESET;
        #1;
        chk({o_pointer_high_byte, o_pointer_low_byte}, ptr_e);
        chk(o_pc_next, PC_RESET);
        chk({13'h0000, o_busy, o_done, o_pc_load}, 16'h0000);
        $display("reset test done");
    endtask
    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_ptr;
        t_jb;
        t_ram;
        t_rst;
        finish_test;
    end
endmodule // ibj_exec_bench

/* File: tb/ibj_exec_props.sv */
/* Checker for ibj_exec: timing of the three instructions, values of the pointer step and jump.
   Assumes it is bound to ibj_exec and sees only its ports. */
`timescale 1ns/1ns
module ibj_exec_props
    import ibj_pkg::*;
(
    input  wire logic        i_core_clk,          // Core clock
    input  wire logic        i_rst,               // Async reset
    input  wire logic        i_start,             // Request pulse
    input  wire logic [7:0]  i_opcode,            // Opcode
    input  wire logic [15:0] i_pc,                // Opcode address
    input  wire logic        i_bit_value,         // Tested bit
    input  wire logic [7:0]  i_rel,               // Displacement
    input  wire logic [7:0]  i_flags_in,          // Flags in
    input  wire logic        o_busy,              // Busy level
    input  wire logic        o_done,              // Done pulse
    input  wire logic        o_pc_load,           // PC load pulse
    input  wire logic [15:0] o_pc_next,           // Next PC
    input  wire logic        o_branch,            // Jump taken
    input  wire logic [7:0]  o_pointer_low_byte,  // Pointer low
    input  wire logic [7:0]  o_pointer_high_byte, // Pointer high
    input  wire logic [7:0]  o_flags_out          // Flags out
);
    // Accepted requests only; a start while busy must be ignored
    wire        go    = i_start && !o_busy;
    wire        g_ptr = go && i_opcode == OP_INC_PTR;
    wire        g_jb  = go && i_opcode == OP_JMP_BIT_SET;
    wire        g_ram = go && (i_opcode & OP_INC_IND_MASK) == OP_INC_IND;
    wire [15:0] ptr   = {o_pointer_high_byte, o_pointer_low_byte};
    wire [15:0] exp_pc = i_pc + JB_LENGTH
                       + (i_bit_value ? {{8{i_rel[7]}}, i_rel} : 16'h0000);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_ptr_inc; g_ptr |=> ptr == $past(ptr) + PTR_STEP; endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer step");
    property p_ptr_time; g_ptr |-> ##2 o_done; endproperty
    a_ptr_time: assert property (p_ptr_time) else $error("inc time");
    property p_flags; !$past(i_rst) |-> o_flags_out == $past(i_flags_in);
    endproperty
    a_flags: assert property (p_flags) else $error("flags changed");
    property p_jb_tgt; g_jb |=> o_pc_next == $past(exp_pc); endproperty
    a_jb_tgt: assert property (p_jb_tgt) else $error("jump target");
    property p_jb_br; g_jb |=> o_branch == $past(i_bit_value); endproperty
    a_jb_br: assert property (p_jb_br) else $error("branch flag");
    property p_jb_load; g_jb |-> ##2 o_pc_load; endproperty
    a_jb_load: assert property (p_jb_load) else $error("no pc load");
    property p_ptr_nold; g_ptr |-> ##2 !o_pc_load; endproperty
    a_ptr_nold: assert property (p_ptr_nold) else $error("pc load");
    property p_ptr_carry; g_ptr && o_pointer_low_byte == 8'hFF |=>
        o_pointer_high_byte == $past(o_pointer_high_byte) + 8'h01;
    endproperty
    a_ptr_carry: assert property (p_ptr_carry) else $error("carry");
    property p_jb_time; g_jb |=> o_busy ##1 (o_done && !o_busy); endproperty
    a_jb_time: assert property (p_jb_time) else $error("jump time");
    property p_ram_time; g_ram |=> (o_busy && !o_done) ##1 o_done; endproperty
    a_ram_time: assert property (p_ram_time) else $error("ram inc");
endmodule // ibj_exec_props

bind ibj_exec ibj_exec_props u_props (.i_core_clk(i_core_clk),
    .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode), .i_pc(i_pc),
    .i_bit_value(i_bit_value), .i_rel(i_rel), .i_flags_in(i_flags_in),
    .o_busy(o_busy), .o_done(o_done), .o_pc_load(o_pc_load),
    .o_pc_next(o_pc_next), .o_branch(o_branch), .o_flags_out(o_flags_out),
    .o_pointer_low_byte(o_pointer_low_byte),
    .o_pointer_high_byte(o_pointer_high_byte));
